// *** edge_source.v ***
/*
 edge_source.v: one edge-triggered interrupt source; compares the selected
 pin with its previous sample and gives a one-cycle qualifying event.
 assumes: pin is already synchronised to clk.
*/
`default_nettype none
`timescale 1ns/10ps
module edge_source (
   input wire clk,
   input wire rst_n,
   input wire pin,
   input wire rise_en,
   input wire fall_en,
   input wire standby,
   output wire event_pulse
);
   reg prev_r;
   reg standby_r;
   reg entry_level_r;
   wire rise;
   wire fall;
   wire entering;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
         standby_r <= 1'b0;
         entry_level_r <= 1'b0;
      end else begin
         prev_r <= pin; // R24
         standby_r <= standby;
         if (entering) begin
            entry_level_r <= pin;
         end
      end
   end
   assign entering = standby & ~standby_r;
   assign rise = pin & ~prev_r & rise_en; // R8 R9
   assign fall = ~pin & prev_r & fall_en;
   // in standby, every edge back toward the entry level is masked
   assign event_pulse = (rise & ~(standby_r & entry_level_r & ~prev_r)) |
      (fall & ~(standby_r & ~entry_level_r & prev_r)); // R14 R13
endmodule
`default_nettype wire

// *** pad_model.sv ***
/*
 pad model: resolves each pin from the block's drive, the pull-up and an
 outside driver. assumes: the block wins over the outside driver.
*/
`timescale 1ns/10ps
`default_nettype none
module pad_model #(
   parameter OD = 8'h00
) (
   input wire logic clk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pull_up_en,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   output logic [7:0] pin_lvl
);
   // ----------------------------------------
   // resolution
   // ----------------------------------------
   logic [7:0] flt = 8'h00;
   // a floating pin toggles every cycle, so the synchroniser never accepts it and a read keeps the last stable level
   always @(posedge clk) flt <= ~flt;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i] && !(OD[i] && pin_out[i])) pin_lvl[i] = pin_out[i];
         else if (ext_en[i]) pin_lvl[i] = ext_val[i];
         else if (pull_up_en[i]) pin_lvl[i] = 1'b1;
         else pin_lvl[i] = flt[i];
      end
   end
endmodule
`default_nettype wire

// *** pin_sync.v ***
/*
 pin_sync.v: three-stage synchroniser for a group of pins; a change is
 accepted once the second and third stages agree.
 assumes: clk is the system clock; inputs are asynchronous pins.
*/
`default_nettype none
`timescale 1ns/10ps
module pin_sync #(
   parameter WIDTH = 8
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] s1_r;
   reg [WIDTH-1:0] s2_r;
   reg [WIDTH-1:0] s3_r;
   integer i;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= {WIDTH{1'b0}};
         s2_r <= {WIDTH{1'b0}};
         s3_r <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         s1_r <= async_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (s2_r[i] == s3_r[i]) begin
               sync_out[i] <= s3_r[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** port_two_consts.vh ***
/*
 port_two_consts.vh: register offsets, field positions, reset values and
 vector codes for the eight-bit port with external interrupt sources.
 assumes: included by bare name; definitions only.
*/
`ifndef PORT_TWO_CONSTS_VH
`define PORT_TWO_CONSTS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_PORT_OUTPUT_LATCH 16'hFE48
`define OFS_PORT_DIRECTION 16'hFE49
`define OFS_EXT_IRQ_AB_CONTROL 16'hFE4A
`define OFS_EXT_IRQ_AB_SELECT 16'hFE4B
`define OFS_EXT_IRQ_CD_CONTROL 16'hFE4E
`define OFS_INPUT_DISABLE_MASK 16'hFE67
`define OFS_PORT_LATCH_RMW 16'hFE50
`define OFS_PORT_STATUS 16'hFE51
// ----------------------------------------
// field positions (control and select registers, low source in bits 3..0)
// ----------------------------------------
`define BIT_LO_ENABLE 0
`define BIT_LO_FLAG 1
`define BIT_LO_FALL 2
`define BIT_LO_RISE 3
`define BIT_HI_ENABLE 4
`define BIT_HI_FLAG 5
`define BIT_HI_FALL 6
`define BIT_HI_RISE 7
`define BIT_A_FUNC_LO 0
`define BIT_A_PIN_LO 2
`define BIT_B_FUNC_LO 4
`define BIT_B_PIN_LO 6
// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define RST_REG 8'h00
`define FUNC_NONE 2'h0
`define FUNC_T1_CLK 2'h1
`define FUNC_T0L_CAP 2'h2
`define FUNC_T0H_CAP 2'h3
`define VEC_IRQ_A 16'h0013
`define VEC_IRQ_B 16'h001B
`define VEC_IRQ_C 16'h0023
`define VEC_IRQ_D 16'h002B
`define SYNC_STAGES 3
`endif

// *** port_two_ext_interrupts.v ***
/*
 port_two_ext_interrupts.v: eight-bit port with direction, pull-up and
 input-disable control, edge interrupt sources a, b (selectable pins) and
 c, d (fixed pins), register port, wake request and timer side strobes.
 assumes: a cpu register port with read data one cycle after the strobe,
 a pad ring that resolves pin level from out and enable, and a standby
 controller that drives hold_standby and halt_standby.
*/
// Summary of operation
// R1 - reading the port latch register returns live pin levels
// R2 - read-modify-write on the port latch works from the stored latch
// R3 - direction bit one makes the pin an output, zero an input
// R4 - pull-up on only when direction is zero and latch is one
// R5 - output drives latch value; open-drain releases high; input zero floats
// R6 - pin levels readable whatever the direction setting
// R7 - input-disable bit blocks the pin and reads as one
// R8 - source b edge field: none, falling, rising, both
// R9 - source a edge field: none, falling, rising, both
// R10 - flags set by edges, never cleared by hardware; software writes zero
// R11 - source b flag and enable give wake and vector 001B request
// R12 - source a flag and enable give wake and vector 0013 request
// R13 - edges in deep standby set flags; wake only if enabled
// R14 - in standby, edges from the entry level toward itself are ignored
// R15 - software should use both edges for standby wake
// R16 - after wake the cpu sits in light standby until interrupt accepted
// R17 - source b pin select picks pin 4 to 7
// R18 - source a pin select picks pin 0 to 3
// R19 - source b function: none, timer 1 clock, timer 0 low/high capture
// R20 - pins 0 and 4 are fixed sources c, d with capture-1 strobes
// R21 - source a function: none, timer 1 clock, timer 0 low/high capture
// R22 - sources c and d request vectors 0023 and 002B
// R23 - pin states are held unchanged throughout standby
// R24 - edges found by comparing each sample with the previous one
`include "port_two_consts.vh"
`default_nettype none
`timescale 1ns/10ps
module port_two_ext_interrupts #(
   parameter WIDTH = 8,
   parameter OPEN_DRAIN = 8'h00
) (
   input wire clk,
   input wire rst_n,
   input wire [15:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] pin_out,
   output reg [WIDTH-1:0] pin_oe,
   output reg [WIDTH-1:0] pull_up_en,
   input wire hold_standby,
   input wire halt_standby,
   input wire irq_accepted,
   output wire standby_release,
   output reg light_standby_req,
   output wire irq_a_req,
   output wire irq_b_req,
   output wire irq_c_req,
   output wire irq_d_req,
   output reg t1_count_clk,
   output reg t0l_capture,
   output reg t0h_capture,
   output reg t0l_capture1,
   output reg t0h_capture1
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] latch_r;
   reg [7:0] dir_r;
   reg [7:0] ab_ctl_r;
   reg [7:0] ab_sel_r;
   reg [7:0] cd_ctl_r;
   reg [7:0] inh_r;
   reg [7:0] ab_ctl_nxt;
   reg [7:0] cd_ctl_nxt;
   wire [WIDTH-1:0] pin_sync_w;
   wire [7:0] pin_read;
   wire standby;
   wire ev_a;
   wire ev_b;
   wire ev_c;
   wire ev_d;
   wire sel_a;
   wire sel_b;
   wire [1:0] func_a;
   wire [1:0] func_b;
   // decoding used by both sources a and b
   function [1:0] func_hit;
      input [1:0] func;
      input ev;
      input [1:0] code;
      begin
         func_hit = {1'b0, ev & (func == code)};
      end
   endfunction
   // ----------------------------------------
   // pin input path
   // ----------------------------------------
   pin_sync #(
      .WIDTH(WIDTH)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(pin_in),
      .sync_out(pin_sync_w)
   );
   assign pin_read = pin_sync_w | inh_r; // R7 R1 R6
   assign standby = hold_standby | halt_standby;
   assign sel_a = pin_read[{1'b0, ab_sel_r[`BIT_A_PIN_LO+1 -: 2]}]; // R18
   assign sel_b = pin_read[{1'b1, ab_sel_r[`BIT_B_PIN_LO+1 -: 2]}]; // R17
   assign func_a = ab_sel_r[`BIT_A_FUNC_LO+1 -: 2];
   assign func_b = ab_sel_r[`BIT_B_FUNC_LO+1 -: 2];
   // ----------------------------------------
   // edge sources
   // ----------------------------------------
   edge_source u_src_a (
      .clk(clk),
      .rst_n(rst_n),
      .pin(sel_a),
      .rise_en(ab_ctl_r[`BIT_LO_RISE]),
      .fall_en(ab_ctl_r[`BIT_LO_FALL]),
      .standby(hold_standby),
      .event_pulse(ev_a)
   ); // R9
   edge_source u_src_b (
      .clk(clk),
      .rst_n(rst_n),
      .pin(sel_b),
      .rise_en(ab_ctl_r[`BIT_HI_RISE]),
      .fall_en(ab_ctl_r[`BIT_HI_FALL]),
      .standby(hold_standby),
      .event_pulse(ev_b)
   ); // R8
   edge_source u_src_c (
      .clk(clk),
      .rst_n(rst_n),
      .pin(pin_read[0]),
      .rise_en(cd_ctl_r[`BIT_LO_RISE]),
      .fall_en(cd_ctl_r[`BIT_LO_FALL]),
      .standby(1'b0),
      .event_pulse(ev_c)
   ); // R20
   edge_source u_src_d (
      .clk(clk),
      .rst_n(rst_n),
      .pin(pin_read[4]),
      .rise_en(cd_ctl_r[`BIT_HI_RISE]),
      .fall_en(cd_ctl_r[`BIT_HI_FALL]),
      .standby(1'b0),
      .event_pulse(ev_d)
   ); // R20
   // ----------------------------------------
   // register write and flag update
   // ----------------------------------------
   always @* begin
      ab_ctl_nxt = ab_ctl_r;
      cd_ctl_nxt = cd_ctl_r;
      if (wr && addr == `OFS_EXT_IRQ_AB_CONTROL) begin
         ab_ctl_nxt = wdata; // R10
      end
      if (wr && addr == `OFS_EXT_IRQ_CD_CONTROL) begin
         cd_ctl_nxt = wdata;
      end
      // a set in the clearing cycle wins, so no edge is lost
      if (ev_a) begin
         ab_ctl_nxt[`BIT_LO_FLAG] = 1'b1; // R10 R13
      end
      if (ev_b) begin
         ab_ctl_nxt[`BIT_HI_FLAG] = 1'b1; // R10 R13
      end
      if (ev_c) begin
         cd_ctl_nxt[`BIT_LO_FLAG] = 1'b1;
      end
      if (ev_d) begin
         cd_ctl_nxt[`BIT_HI_FLAG] = 1'b1;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_r <= `RST_REG;
         dir_r <= `RST_REG;
         ab_ctl_r <= `RST_REG;
         ab_sel_r <= `RST_REG;
         cd_ctl_r <= `RST_REG;
         inh_r <= `RST_REG;
      end else begin
         ab_ctl_r <= ab_ctl_nxt;
         cd_ctl_r <= cd_ctl_nxt;
         if (wr) begin
            case (addr)
               `OFS_PORT_OUTPUT_LATCH: latch_r <= wdata;
               // read-modify-write path: the cpu fetched the latch, not pins
               `OFS_PORT_LATCH_RMW: latch_r <= wdata; // R2
               `OFS_PORT_DIRECTION: dir_r <= wdata; // R3
               `OFS_EXT_IRQ_AB_SELECT: ab_sel_r <= wdata;
               `OFS_INPUT_DISABLE_MASK: inh_r <= wdata;
               default: ;
            endcase
         end
      end
   end
   // ----------------------------------------
   // register read, one cycle after the strobe
   // ----------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `OFS_PORT_OUTPUT_LATCH: rdata <= pin_read; // R1 R6 R7
            `OFS_PORT_LATCH_RMW: rdata <= latch_r; // R2
            `OFS_PORT_DIRECTION: rdata <= dir_r;
            `OFS_EXT_IRQ_AB_CONTROL: rdata <= ab_ctl_r;
            `OFS_EXT_IRQ_AB_SELECT: rdata <= ab_sel_r;
            `OFS_EXT_IRQ_CD_CONTROL: rdata <= cd_ctl_r;
            `OFS_INPUT_DISABLE_MASK: rdata <= inh_r;
            `OFS_PORT_STATUS: rdata <= {5'h00, light_standby_req, standby_release, standby};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
   // ----------------------------------------
   // pad drive, held frozen during standby
   // ----------------------------------------
   integer i;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= 8'h00;
         pin_oe <= 8'h00;
         pull_up_en <= 8'h00;
      end else if (!standby) begin // R23
         for (i = 0; i < WIDTH; i = i + 1) begin
            pin_out[i] <= latch_r[i]; // R5
            // open-drain high is a released pin
            pin_oe[i] <= dir_r[i] & ~(latch_r[i] & OPEN_DRAIN[i]); // R3 R5
            pull_up_en[i] <= ~dir_r[i] & latch_r[i]; // R4
         end
      end
   end
   // ----------------------------------------
   // requests, wake and timer strobes
   // ----------------------------------------
   assign irq_a_req = ab_ctl_r[`BIT_LO_FLAG] & ab_ctl_r[`BIT_LO_ENABLE]; // R12
   assign irq_b_req = ab_ctl_r[`BIT_HI_FLAG] & ab_ctl_r[`BIT_HI_ENABLE]; // R11
   assign irq_c_req = cd_ctl_r[`BIT_LO_FLAG] & cd_ctl_r[`BIT_LO_ENABLE]; // R22
   assign irq_d_req = cd_ctl_r[`BIT_HI_FLAG] & cd_ctl_r[`BIT_HI_ENABLE]; // R22
   assign standby_release = irq_a_req | irq_b_req; // R11 R12 R13
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         light_standby_req <= 1'b0;
         t1_count_clk <= 1'b0;
         t0l_capture <= 1'b0;
         t0h_capture <= 1'b0;
         t0l_capture1 <= 1'b0;
         t0h_capture1 <= 1'b0;
      end else begin
         // simultaneous a and b events count once
         if (hold_standby && standby_release) begin
            light_standby_req <= 1'b1; // R16
         end else if (irq_accepted) begin
            light_standby_req <= 1'b0; // R16
         end
         t1_count_clk <= func_hit(func_a, ev_a, `FUNC_T1_CLK) != 2'h0 ||
            func_hit(func_b, ev_b, `FUNC_T1_CLK) != 2'h0; // R21 R19
         t0l_capture <= func_hit(func_a, ev_a, `FUNC_T0L_CAP) != 2'h0 ||
            func_hit(func_b, ev_b, `FUNC_T0L_CAP) != 2'h0; // R21 R19
         t0h_capture <= func_hit(func_a, ev_a, `FUNC_T0H_CAP) != 2'h0 ||
            func_hit(func_b, ev_b, `FUNC_T0H_CAP) != 2'h0; // R21 R19
         t0l_capture1 <= ev_c; // R20
         t0h_capture1 <= ev_d; // R20
      end
   end
endmodule
`default_nettype wire

// *** port_two_ext_interrupts_assertions.sv ***
/*
 checker: port and wake relations of the port block, seen at its ports.
 assumes: bound to every port_two_ext_interrupts instance; OPEN_DRAIN zero.
*/
`timescale 1ns/10ps
`default_nettype none
module port_two_ext_interrupts_assertions #(
   parameter WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic [WIDTH-1:0] pin_in,
   input wire logic [WIDTH-1:0] pin_out,
   input wire logic [WIDTH-1:0] pin_oe,
   input wire logic [WIDTH-1:0] pull_up_en,
   input wire logic hold_standby,
   input wire logic halt_standby,
   input wire logic irq_accepted,
   input wire logic standby_release,
   input wire logic light_standby_req,
   input wire logic irq_a_req,
   input wire logic irq_b_req,
   input wire logic irq_c_req,
   input wire logic irq_d_req,
   input wire logic t1_count_clk,
   input wire logic t0l_capture,
   input wire logic t0h_capture,
   input wire logic t0l_capture1,
   input wire logic t0h_capture1
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire sb = hold_standby | halt_standby;
   property p_pull_off; (pull_up_en & pin_oe) == '0; endproperty
   a_pull_off: assert property (p_pull_off) else $error("pull-up on a driven pin");
   property p_release; standby_release == (irq_a_req | irq_b_req); endproperty
   a_release: assert property (p_release) else $error("wake request mismatch");
   property p_flag_hold; $fell(irq_a_req) |-> $past(wr) && $past(addr) == 16'hFE4A; endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped alone");
   property p_freeze; $past(sb) |-> $stable(pin_out) && $stable(pin_oe) && $stable(pull_up_en);
   endproperty
   a_freeze: assert property (p_freeze) else $error("pins moved in standby");
   // the one idle cycle stands for the register stage ahead of the pads
   property p_oe; (wr && addr == 16'hFE49 && !sb) ##1 !sb |=> pin_oe == $past(wdata, 2);
   endproperty
   a_oe: assert property (p_oe) else $error("enable not direction");
   property p_out; (wr && addr == 16'hFE48 && !sb) ##1 !sb |=> pin_out == $past(wdata, 2);
   endproperty
   a_out: assert property (p_out) else $error("drive not latch");
   property p_light_set; $rose(light_standby_req) |-> $past(hold_standby && standby_release);
   endproperty
   a_light_set: assert property (p_light_set) else $error("light standby without wake");
   property p_light_keep; light_standby_req && !irq_accepted |=> light_standby_req; endproperty
   a_light_keep: assert property (p_light_keep) else $error("light standby left early");
   c_wake: cover property (irq_a_req && hold_standby);
   c_light: cover property ($rose(light_standby_req));
   c_cap: cover property (t0h_capture);
endmodule
bind port_two_ext_interrupts port_two_ext_interrupts_assertions #(.WIDTH(WIDTH)) u_chk (.*);
`default_nettype wire

// *** test_port_two_ext_interrupts.sv ***
/*
 bench: register, pin, edge and standby sequences with expected values.
 assumes: pads modelled by pad_model; standby levels driven here.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_port_two_ext_interrupts;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, hold = 0, halt = 0, acc = 0;
   logic [15:0] addr = 0;
   logic [7:0] wdata = 0, ext_val = 0, ext_en = 8'hFF;
   wire [7:0] rdata, lvl, pout, poe, pu;
   wire rel, lreq, ra, rb, rc, rdd, t1, t0l, t0h, c1l, c1h;
   int n_mismatch = 0, n_tests = 0, cyc = 0, k;
   int cnt[5] = '{0, 0, 0, 0, 0};
   logic [15:0] regs[6] = '{16'hFE48, 16'hFE49, 16'hFE4A, 16'hFE4B, 16'hFE4E, 16'hFE67};
   port_two_ext_interrupts u_port_two_ext_interrupts (.clk(clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(lvl),
      .pin_out(pout), .pin_oe(poe), .pull_up_en(pu), .hold_standby(hold),
      .halt_standby(halt), .irq_accepted(acc), .standby_release(rel),
      .light_standby_req(lreq), .irq_a_req(ra), .irq_b_req(rb), .irq_c_req(rc),
      .irq_d_req(rdd), .t1_count_clk(t1), .t0l_capture(t0l), .t0h_capture(t0h),
      .t0l_capture1(c1l), .t0h_capture1(c1h));
   pad_model u_pad_model (.clk(clk), .pin_out(pout), .pin_oe(poe), .pull_up_en(pu),
      .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(lvl));
   // ----------------------------------------
   // clock, strobe counters, timeout
   // ----------------------------------------
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      cnt[0] += c1l;
      cnt[1] += t1;
      cnt[2] += t0l;
      cnt[3] += t0h;
      cnt[4] += c1h;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report;
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task final_report;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task wreg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 0;
   endtask
   task rchk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1;
      addr <= a;
      @(posedge clk);
      rd <= 0;
      #1 `CHK(rdata, e)
   endtask
   // source a or b on pin s of its group, edge code e, function code e
   task src(input bit b, input logic [1:0] s, input logic [1:0] e);
      int p;
      p = b * 4 + s;
      wreg(16'hFE4A, 8'h00);
      ext_val <= 8'h00;
      repeat (8) @(posedge clk);
      wreg(16'hFE4B, b ? {s, e, 4'h0} : {4'h0, s, e});
      wreg(16'hFE4A, b ? {e, 6'h10} : {4'h0, e, 2'h1});
      k = cnt[e];
      ext_val[p] <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK(b ? rb : ra, e[1])
      `CHK(rel, e[1])
      wreg(16'hFE4A, b ? {e, 6'h10} : {4'h0, e, 2'h1});
      ext_val[p] <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK(b ? rb : ra, e[0])
      `CHK(cnt[e] - k, (e == 0) ? 0 : e[1] + e[0])
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1;
      for (int i = 0; i < 6; i++) rchk(regs[i], 8'h00);
      rchk(16'hFE4F, 8'h00);
      ext_en <= 8'h0A;
      ext_val <= 8'h0A;
      wreg(16'hFE49, 8'hF0);
      wreg(16'hFE48, 8'hA5);
      repeat (8) @(posedge clk);
      `CHK(poe, 8'hF0)
      `CHK(pout & poe, 8'hA0)
      `CHK(pu, 8'h05)
      rchk(16'hFE48, 8'hAF);
      rchk(16'hFE50, 8'hA5);
      wreg(16'hFE67, 8'h50);
      rchk(16'hFE48, 8'hFF);
      wreg(16'hFE67, 8'h00);
      wreg(16'hFE49, 8'h00);
      wreg(16'hFE48, 8'h00);
      ext_en <= 8'hFF;
      ext_val <= 8'h00;
      for (int b = 0; b < 2; b++)
         for (int s = 0; s < 4; s++)
            for (int e = 0; e < 4; e++) src(b, s, e);
      wreg(16'hFE4A, 8'h00);
      wreg(16'hFE4E, 8'hDD);
      ext_val <= 8'h11;
      repeat (8) @(posedge clk);
      `CHK({rc, rdd}, 2'b11)
      `CHK(cnt[0] + cnt[4], 2)
      rchk(16'hFE4E, 8'hFF);
      // pins 0 and 4 fall before source a is armed, so no edge sets its flag early
      ext_val <= 8'h00;
      wreg(16'hFE4E, 8'h00);
      wreg(16'hFE4B, 8'h00);
      wreg(16'hFE4A, 8'h0D);
      repeat (8) @(posedge clk);
      `CHK({ra, rel}, 2'b00)
      hold <= 1;
      wreg(16'hFE49, 8'h0F);
      ext_val <= 8'h01;
      repeat (8) @(posedge clk);
      `CHK({ra, rel, lreq}, 3'b111)
      rchk(16'hFE51, 8'h07);
      `CHK(poe, 8'h00)
      wreg(16'hFE4A, 8'h0D);
      ext_val <= 8'h00;
      repeat (8) @(posedge clk);
      `CHK(ra, 1'b0)
      hold <= 0;
      halt <= 1;
      @(posedge clk);
      `CHK(lreq, 1'b1)
      acc <= 1;
      @(posedge clk);
      acc <= 0;
      @(posedge clk);
      `CHK(lreq, 1'b0)
      halt <= 0;
      repeat (3) @(posedge clk);
      `CHK(poe, 8'h0F)
      final_report;
   end
endmodule
`default_nettype wire
